// ---- rtl/cmpev_top.sv ----
// Comparator event, output routing, blanking and reference control with APB slave
`timescale 1ns/10ps
`default_nettype none
module cmpev_top
  import cmpev_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator and mask inputs
  input wire logic comparator_raw_i,
  input wire logic mask_a_input_i,
  input wire logic mask_b_input_i,
  // Port direction of the shared reference pin (1 = input)
  input wire logic port_direction_bit_i,
  input wire logic port_data_i,
  // Comparator output pin
  output logic comparator_pin_o,
  output logic comparator_pin_oe_n_o,
  // Reference pin drive
  output logic external_reference_pin_o,
  output logic external_reference_pin_oe_n_o,
  output logic reference_analog_drive_o,
  // Reference settings, gate output and event flag
  output cmpev_vref_t vref_o,
  output logic blank_o,
  output logic comparator_event_o,
  // Interrupt
  output logic irq_o
);

  // Register state
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] mask_q, mask_d;
  logic [15:0] vref_q, vref_d;
  logic evt_q, evt_d;
  logic res_q, res_d;
  logic res_prev_q, res_prev_d;
  logic irq_stat_q, irq_stat_d;
  logic irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d;
  logic wait_q, wait_d;

  logic wr_en, rd_en, hit, evt_fire, evt_clr;
  logic pol_res, rise, fall;
  cmpev_edge_t edge_sel;

  // One wait state: read data is registered in the first access cycle, ready in the second
  assign pready = wait_q;
  assign wr_en = psel & penable & pwrite & wait_q;
  assign rd_en = psel & penable & ~pwrite & ~wait_q;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & ~hit & wait_q;

  // Address hit check shared by read and write
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == CMPEV_CTRL_OFS) || (a == CMPEV_MASK_OFS) || (a == CMPEV_VREF_OFS)
            || (a == CMPEV_IRQ_STAT_OFS) || (a == CMPEV_IRQ_MASK_OFS);
  endfunction : addr_hit

  assign hit = addr_hit(paddr);

  // Blanking gate and reference decode
  cmpev_mask_gate u_gate (
    .sel_i(mask_q[3:0]),
    .mask_a_input_i(mask_a_input_i),
    .mask_b_input_i(mask_b_input_i),
    .blank_o(blank_o)
  );

  cmpev_ref_ctrl u_ref (
    .vref_reg_i(vref_q),
    .vref_o(vref_o)
  );

  // Polarity-adjusted comparator result and edge detect
  always_comb
  begin
    pol_res = ctrl_q[CMPEV_CTRL_EN_POS]
            & (comparator_raw_i ^ ctrl_q[CMPEV_CTRL_INV_POS]);
    res_d = pol_res;
    res_prev_d = res_q;
    rise = res_q & ~res_prev_q;
    fall = ~res_q & res_prev_q;
    edge_sel = cmpev_edge_t'(ctrl_q[CMPEV_CTRL_EDGE_POS +: 2]);
    case (edge_sel)
      CMPEV_EDGE_RISE: evt_fire = rise;
      CMPEV_EDGE_FALL: evt_fire = fall;
      CMPEV_EDGE_BOTH: evt_fire = rise | fall;
      default: evt_fire = 1'b0;
    endcase
    evt_fire = evt_fire & ~evt_q & ctrl_q[CMPEV_CTRL_EN_POS];
  end

  // Event flag clear by writing zero to it in the control register
  assign evt_clr = wr_en && (paddr == CMPEV_CTRL_OFS) && !pwdata[CMPEV_CTRL_EVT_POS];

  // Register next values
  always_comb
  begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    vref_d = vref_q;
    irq_mask_d = irq_mask_q;
    evt_d = evt_q;
    irq_stat_d = irq_stat_q;
    prdata_d = prdata_q;
    slverr_d = 1'b0;
    wait_d = psel & penable & ~wait_q;
    if (wr_en)
    begin
      if (paddr == CMPEV_CTRL_OFS)
        ctrl_d = pwdata[15:0] & CMPEV_CTRL_WMASK;
      else if (paddr == CMPEV_MASK_OFS)
        mask_d = pwdata[15:0] & CMPEV_MASK_WMASK;
      else if (paddr == CMPEV_VREF_OFS)
        vref_d = pwdata[15:0] & CMPEV_VREF_WMASK;
      else if (paddr == CMPEV_IRQ_STAT_OFS)
        irq_stat_d = irq_stat_q & ~pwdata[0];
      else if (paddr == CMPEV_IRQ_MASK_OFS)
        irq_mask_d = pwdata[0];
    end
    if (evt_clr)
      evt_d = 1'b0;
    // Set wins over a clear in the same cycle
    if (evt_fire)
    begin
      evt_d = 1'b1;
      irq_stat_d = 1'b1;
    end
    if (rd_en)
    begin
      if (paddr == CMPEV_CTRL_OFS)
        prdata_d = {16'h0000, ctrl_q | (16'h0001 << CMPEV_CTRL_EVT_POS) * 16'(evt_q)
                   | (16'h0001 << CMPEV_CTRL_RES_POS) * 16'(res_q)};
      else if (paddr == CMPEV_MASK_OFS)
        prdata_d = {16'h0000, mask_q};
      else if (paddr == CMPEV_VREF_OFS)
        prdata_d = {16'h0000, vref_q};
      else if (paddr == CMPEV_IRQ_STAT_OFS)
        prdata_d = {31'h00000000, irq_stat_q};
      else if (paddr == CMPEV_IRQ_MASK_OFS)
        prdata_d = {31'h00000000, irq_mask_q};
      else
        prdata_d = 32'h00000000;
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= CMPEV_REG_RST;
      mask_q <= CMPEV_REG_RST;
      vref_q <= CMPEV_REG_RST;
      evt_q <= 1'b0;
      res_q <= 1'b0;
      res_prev_q <= 1'b0;
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
      wait_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      vref_q <= vref_d;
      evt_q <= evt_d;
      res_q <= res_d;
      res_prev_q <= res_prev_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
      wait_q <= wait_d;
    end
  end

  // Output routing and reference pin override of the port direction
  always_comb
  begin
    comparator_pin_o = res_q;
    comparator_pin_oe_n_o = ~(ctrl_q[CMPEV_CTRL_OE_POS] & ctrl_q[CMPEV_CTRL_EN_POS]);
    reference_analog_drive_o = vref_o.reference_pin_drive_enable;
    external_reference_pin_o = vref_o.reference_pin_drive_enable ? 1'b0 : port_data_i;
    external_reference_pin_oe_n_o = vref_o.reference_pin_drive_enable ? 1'b1
                                  : port_direction_bit_i;
    comparator_event_o = evt_q;
    irq_o = irq_stat_q & irq_mask_q;
  end

  // Assertions
  a_mask_b_true: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mask_q[3:0] == 4'h8) |-> (blank_o == mask_b_input_i)) else $error("mask b true");
  a_mask_b_inv: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mask_q[3:0] == 4'h4) |-> (blank_o == !mask_b_input_i)) else $error("mask b inv");
  a_mask_a_true: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mask_q[3:0] == 4'h2) |-> (blank_o == mask_a_input_i)) else $error("mask a true");
  a_mask_a_inv: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mask_q[3:0] == 4'h1) |-> (blank_o == !mask_a_input_i)) else $error("mask a inv");
  a_ref_src_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    vref_o.reference_source_select == vref_q[10]) else $error("ref select");
  a_bg_valid: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    vref_o.bandgap_valid == vref_q[9]) else $error("bandgap code");
  a_ref_power: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(vref_q[7]) |-> vref_o.reference_power_enable) else $error("ref power");
  a_pin_override: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    reference_analog_drive_o |-> external_reference_pin_oe_n_o) else $error("pin override");
  a_tap_hi: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    vref_q[5] |-> vref_o.ladder_tap_index == {vref_q[3:0], 2'b00}) else $error("tap hi");
  a_tap_lo: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !vref_q[5] |-> vref_o.ladder_tap_index == 6'd24 + 6'd3 * {2'b00, vref_q[3:0]})
    else $error("tap lo");
  a_evt_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_q && !evt_clr |=> evt_q) else $error("event flag lost");
  a_evt_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    evt_fire |=> evt_q && irq_stat_q) else $error("event not flagged");
  a_cmp_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !ctrl_q[15] |=> !res_q) else $error("disabled comparator active");

endmodule : cmpev_top
`default_nettype wire

// ---- rtl/cmpev_pkg.sv ----
// Package of constants and types for the comparator event and reference control block
package cmpev_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] CMPEV_CTRL_OFS = 8'h00;
  localparam logic [7:0] CMPEV_MASK_OFS = 8'h04;
  localparam logic [7:0] CMPEV_VREF_OFS = 8'h08;
  localparam logic [7:0] CMPEV_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] CMPEV_IRQ_MASK_OFS = 8'h10;

  // Comparator control field positions
  localparam int CMPEV_CTRL_EN_POS = 15;
  localparam int CMPEV_CTRL_OE_POS = 14;
  localparam int CMPEV_CTRL_INV_POS = 13;
  localparam int CMPEV_CTRL_EVT_POS = 9;
  localparam int CMPEV_CTRL_RES_POS = 8;
  localparam int CMPEV_CTRL_EDGE_POS = 6;
  localparam int CMPEV_CTRL_CREF_POS = 4;
  localparam int CMPEV_CTRL_CH_POS = 0;

  // Mask gating field positions
  localparam int CMPEV_MASK_BT_POS = 3;
  localparam int CMPEV_MASK_BN_POS = 2;
  localparam int CMPEV_MASK_AT_POS = 1;
  localparam int CMPEV_MASK_AN_POS = 0;

  // Reference control field positions
  localparam int CMPEV_VREF_SEL_POS = 10;
  localparam int CMPEV_VREF_BG_POS = 8;
  localparam int CMPEV_VREF_PWR_POS = 7;
  localparam int CMPEV_VREF_OE_POS = 6;
  localparam int CMPEV_VREF_RNG_POS = 5;
  localparam int CMPEV_VREF_TAP_POS = 0;

  // Writable bit masks and reset values
  localparam logic [15:0] CMPEV_CTRL_WMASK = 16'hE0D3;
  localparam logic [15:0] CMPEV_MASK_WMASK = 16'h000F;
  localparam logic [15:0] CMPEV_VREF_WMASK = 16'h07EF;
  localparam logic [15:0] CMPEV_REG_RST = 16'h0000;

  // Band-gap source codes
  localparam logic [1:0] CMPEV_BG_PIN = 2'b11;
  localparam logic [1:0] CMPEV_BG_INT = 2'b10;

  // Ladder tap scaling
  localparam int CMPEV_LADDER_HI_DIV = 24;
  localparam int CMPEV_LADDER_LO_DIV = 32;
  localparam int CMPEV_LADDER_LO_BASE = 8;

  // Event edge selections
  typedef enum logic [1:0] {
    CMPEV_EDGE_OFF = 2'b00,
    CMPEV_EDGE_RISE = 2'b01,
    CMPEV_EDGE_FALL = 2'b10,
    CMPEV_EDGE_BOTH = 2'b11
  } cmpev_edge_t;

  // Reference settings carried to the analog side
  typedef struct packed {
    logic reference_power_enable;
    logic reference_pin_drive_enable;
    logic reference_source_select;
    logic [1:0] bandgap_source_select;
    logic bandgap_valid;
    logic reference_range_select;
    logic [3:0] reference_tap_code;
    logic [5:0] ladder_tap_index;
  } cmpev_vref_t;

endpackage : cmpev_pkg

// ---- rtl/cmpev_mask_gate.sv ----
// Blanking AND gate with selectable true or inverted mask inputs
`timescale 1ns/10ps
`default_nettype none
module cmpev_mask_gate
  import cmpev_pkg::*;
(
  // Gate selections
  input wire logic [3:0] sel_i,
  // Mask inputs
  input wire logic mask_a_input_i,
  input wire logic mask_b_input_i,
  // Gate output
  output logic blank_o
);

  // Unselected terms read as one so they drop out of the AND
  always_comb
  begin
    blank_o = (~sel_i[CMPEV_MASK_BT_POS] | mask_b_input_i)
            & (~sel_i[CMPEV_MASK_BN_POS] | ~mask_b_input_i)
            & (~sel_i[CMPEV_MASK_AT_POS] | mask_a_input_i)
            & (~sel_i[CMPEV_MASK_AN_POS] | ~mask_a_input_i)
            & (|sel_i); // No term chosen leaves the gate idle
  end

endmodule : cmpev_mask_gate
`default_nettype wire

// ---- rtl/cmpev_ref_ctrl.sv ----
// Reference ladder tap and source selection for the comparator reference
`timescale 1ns/10ps
`default_nettype none
module cmpev_ref_ctrl
  import cmpev_pkg::*;
(
  // Reference control register
  input wire logic [15:0] vref_reg_i,
  // Decoded settings
  output cmpev_vref_t vref_o
);

  // Tap index in 1/96 steps of the source: high range code*4, low range 24+code*3
  function automatic logic [5:0] tap_index(input logic rng, input logic [3:0] code);
    logic [5:0] c;
    c = {2'b00, code};
    if (rng)
      tap_index = 6'((96 / CMPEV_LADDER_HI_DIV) * c);
    else
      tap_index = 6'((96 * CMPEV_LADDER_LO_BASE) / CMPEV_LADDER_LO_DIV
                     + (96 / CMPEV_LADDER_LO_DIV) * c);
  endfunction : tap_index

  // Field decode
  always_comb
  begin
    vref_o.reference_power_enable = vref_reg_i[CMPEV_VREF_PWR_POS];
    vref_o.reference_pin_drive_enable = vref_reg_i[CMPEV_VREF_OE_POS]
                                      & vref_reg_i[CMPEV_VREF_PWR_POS];
    vref_o.reference_source_select = vref_reg_i[CMPEV_VREF_SEL_POS];
    vref_o.bandgap_source_select = vref_reg_i[CMPEV_VREF_BG_POS +: 2];
    vref_o.bandgap_valid = (vref_reg_i[CMPEV_VREF_BG_POS +: 2] == CMPEV_BG_PIN)
                         | (vref_reg_i[CMPEV_VREF_BG_POS +: 2] == CMPEV_BG_INT);
    vref_o.reference_range_select = vref_reg_i[CMPEV_VREF_RNG_POS];
    vref_o.reference_tap_code = vref_reg_i[CMPEV_VREF_TAP_POS +: 4];
    vref_o.ladder_tap_index = tap_index(vref_reg_i[CMPEV_VREF_RNG_POS],
                                        vref_reg_i[CMPEV_VREF_TAP_POS +: 4]);
  end

endmodule : cmpev_ref_ctrl
`default_nettype wire

// ---- tb/cmpev_analog_model.sv ----
// Analog comparator model that compares the input level against the ladder tap
`timescale 1ns/10ps
`default_nettype none
module cmpev_analog_model
  import cmpev_pkg::*;
(
  // Reference settings and input level in 1/96 of the source
  input wire cmpev_vref_t vref_i,
  input wire logic [6:0] vin_i,
  // Raw comparator result
  output logic comparator_raw_o
);
  // Input above the tap level gives a high result
  assign comparator_raw_o = (vin_i > {1'b0, vref_i.ladder_tap_index});
endmodule : cmpev_analog_model
`default_nettype wire

// ---- tb/cmpev_top_test.sv ----
// Self-checking bench for the comparator event and reference control block
`timescale 1ns/10ps
`default_nettype none
module cmpev_top_test
  import cmpev_pkg::*;
;
  typedef struct packed {
    logic [15:0] vr;
    logic [3:0] msk;
    logic a;
    logic b;
    logic [5:0] tap;
    logic blk;
  } cmpev_row_t;
  logic ref_clk_i, pready, pslverr, raw, pin, pin_oe_n, rpin, rpin_oe_n, rdrv, blank, evt, irq;
  logic rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic mask_a_input = 1'b0, mask_b_input = 1'b0, pdir = 1'b1, pdat = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [6:0] vin = 7'h00;
  cmpev_vref_t vref;
  int n_mismatch = 0;
  int checks = 0;
  // Register settings beside the gate level and tap they should give
  cmpev_row_t rows [8] = '{
    '{16'h07EF, 4'hF, 1'b1, 1'b1, 6'h3C, 1'b0}, '{16'h0000, 4'h0, 1'b0, 1'b0, 6'h18, 1'b0},
    '{16'h0020, 4'h8, 1'b0, 1'b1, 6'h00, 1'b1}, '{16'h000F, 4'h4, 1'b0, 1'b0, 6'h45, 1'b1},
    '{16'h02A5, 4'h2, 1'b1, 1'b0, 6'h14, 1'b1}, '{16'h0140, 4'h1, 1'b0, 1'b1, 6'h18, 1'b1},
    '{16'h0487, 4'h3, 1'b1, 1'b0, 6'h2D, 1'b0}, '{16'h00C3, 4'h9, 1'b0, 1'b1, 6'h21, 1'b1}};

  cmpev_top i_cmpev_top (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_raw_i(raw), .mask_a_input_i(mask_a_input), .mask_b_input_i(mask_b_input),
    .port_direction_bit_i(pdir), .port_data_i(pdat), .comparator_pin_o(pin),
    .comparator_pin_oe_n_o(pin_oe_n), .external_reference_pin_o(rpin),
    .external_reference_pin_oe_n_o(rpin_oe_n), .reference_analog_drive_o(rdrv),
    .vref_o(vref), .blank_o(blank), .comparator_event_o(evt), .irq_o(irq));

  cmpev_analog_model i_cmpev_analog_model (.vref_i(vref), .vin_i(vin), .comparator_raw_o(raw));

  // Free-running clock of 100 ns
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  // One bus transfer; response is taken at the edge where pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
    if (n >= 20)
    begin
      n_mismatch++;
      test_done();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(rd, want);
  endtask : rdchk

  // Main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1 chk({pin_oe_n, rpin_oe_n, rdrv, irq, evt, blank}, 6'b110000);
    for (int k = 0; k < 5; k++)
      rdchk(8'(4 * k), 32'h0);
    foreach (rows[i])
    begin
      mask_a_input <= rows[i].a;
      mask_b_input <= rows[i].b;
      pdir <= i[0];
      pdat <= i[1];
      wr(CMPEV_MASK_OFS, {28'h0, rows[i].msk});
      wr(CMPEV_VREF_OFS, {16'h0, rows[i].vr});
      chk(blank, rows[i].blk);
      chk(vref.ladder_tap_index, rows[i].tap);
      chk(vref.reference_tap_code, rows[i].vr[3:0]);
      chk({vref.reference_source_select, vref.bandgap_source_select,
           vref.reference_power_enable, vref.reference_pin_drive_enable,
           vref.reference_range_select},
          {rows[i].vr[10:7], rows[i].vr[6] & rows[i].vr[7], rows[i].vr[5]});
      chk(vref.bandgap_valid, rows[i].vr[9]);
      chk(rdrv, rows[i].vr[7] & rows[i].vr[6]);
      chk(rpin_oe_n, (rows[i].vr[7] & rows[i].vr[6]) | i[0]);
      if (!(rows[i].vr[7] & rows[i].vr[6]))
        chk(rpin, i[1]);
      rdchk(CMPEV_VREF_OFS, {16'h0, rows[i].vr});
    end
    // Every edge selection: rise, clear status, then fall with the event flag not cleared
    wr(CMPEV_VREF_OFS, 32'h0088);
    wr(CMPEV_IRQ_MASK_OFS, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      wr(CMPEV_CTRL_OFS, 32'hC000 | (m << 6));
      chk(pin_oe_n, 1'b0);
      vin <= 7'd96;
      repeat (4) @(posedge ref_clk_i);
      #1 chk({evt, irq, pin}, {m[0], m[0], 1'b1});
      rdchk(CMPEV_CTRL_OFS, 32'hC100 | (m << 6) | ((m & 1) << 9));
      wr(CMPEV_IRQ_STAT_OFS, 32'h1);
      vin <= 7'd0;
      repeat (4) @(posedge ref_clk_i);
      #1 chk({evt, irq}, {m[0] | m[1], m[1] & ~m[0]});
      wr(CMPEV_CTRL_OFS, 32'hC000 | (m << 6));
      wr(CMPEV_IRQ_STAT_OFS, 32'h1);
      chk({evt, irq}, 2'b00);
    end
    // Inverted result, then disabled comparator
    wr(CMPEV_CTRL_OFS, 32'hE000);
    repeat (3) @(posedge ref_clk_i);
    #1 chk(pin, 1'b1);
    rdchk(CMPEV_CTRL_OFS, 32'hE100);
    wr(CMPEV_CTRL_OFS, 32'h4000);
    chk(pin_oe_n, 1'b1);
    vin <= 7'd96;
    wr(CMPEV_CTRL_OFS, 32'hFFFFFFFF);
    rdchk(CMPEV_CTRL_OFS, 32'hE0D3);
    apb(1'b0, 8'h14, 32'h0, rd, err);
    chk({err, rd}, {1'b1, 32'h0});
    test_done();
  end
endmodule : cmpev_top_test
`default_nettype wire
